// ===== hw/baseline_track.sv
`timescale 1ns/100ps
`default_nettype none
`include "baseline_track_defs.svh"
// Per-channel baseline tracking with reference drift compensation
// and long touch release; one pass per SAMPLE_STROBE_IN.
module baseline_track #(
    parameter int NCH = 3,
    parameter int W   = 16,
    parameter int CW  = 8
) (
    input  wire logic             CLK_IN,
    input  wire logic             RESETN_IN,
    input  wire logic             CE_IN,
    input  wire logic             SAMPLE_STROBE_IN,
    input  wire logic [NCH*W-1:0] COUNTS_IN,
    input  wire logic [NCH-1:0]   PROX_IN,
    input  wire logic [NCH-1:0]   TOUCH_IN,
    input  wire logic [NCH*2-1:0] ROLE_IN,
    input  wire logic [NCH*2-1:0] REFERENCE_SELECT_IN,
    input  wire logic [NCH*8-1:0] EVENT_MASK_IN,
    input  wire logic [NCH*16-1:0] WEIGHT_IN,
    input  wire logic [3:0]       LONG_BETA_IN,
    input  wire logic [3:0]       SETTLE_BETA_IN,
    input  wire logic             RELEASE_ENABLE_IN,
    input  wire logic [W-1:0]     SETTLE_THRESHOLD_IN,
    input  wire logic [CW-1:0]    SNAPSHOT_DELAY_IN,
    input  wire logic [7:0]       RELEASE_PERCENT_IN,
    output logic      [NCH*W-1:0] LONG_TERM_BASELINE_OUT,
    output logic      [NCH*W-1:0] SETTLE_TRACKING_BASELINE_OUT,
    output logic      [NCH*W-1:0] DELTA_SNAPSHOT_OUT,
    output logic      [NCH-1:0]   AUTO_TUNING_INHIBIT_OUT,
    output logic      [NCH-1:0]   RESEED_OUT,
    output logic                  DONE_OUT
);
    baseline_track_pkg::seq_t state_q;
    logic [NCH*W-1:0] long_q;
    logic [NCH*W-1:0] long_prev_q;
    logic [NCH*W-1:0] settle_q;
    logic [NCH*W-1:0] long_filt;
    logic [NCH*W-1:0] settle_filt;
    logic [NCH*W-1:0] snap_w;
    logic [NCH-1:0]   release_w;
    logic [NCH-1:0]   inhibit_w;
    logic [NCH*W-1:0] long_d;
    logic [15:0]      status_hi;

    // Upper status byte: prox/touch per channel pairs
    always_comb begin
        status_hi = '0;
        for (int c = 0; c < NCH; c++) begin
            status_hi[2*c+`STATUS_PROX_BIT]  = PROX_IN[c];
            status_hi[2*c+`STATUS_TOUCH_BIT] = TOUCH_IN[c];
        end
    end

    // Sequencer: compute drift first, then commit baselines
    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            state_q <= baseline_track_pkg::ST_IDLE;
        end else if (CE_IN) begin
            case (state_q)
                baseline_track_pkg::ST_IDLE: begin
                    if (SAMPLE_STROBE_IN) state_q <= baseline_track_pkg::ST_COMPUTE;
                end
                baseline_track_pkg::ST_COMPUTE: state_q <= baseline_track_pkg::ST_COMMIT;
                baseline_track_pkg::ST_COMMIT:  state_q <= baseline_track_pkg::ST_IDLE;
                default: state_q <= baseline_track_pkg::ST_IDLE;
            endcase
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            logic [1:0]  role;
            logic [1:0]  sel;
            logic        active;
            logic signed [W:0]  drift;
            logic signed [W+17:0] prod;
            logic signed [W+17:0] corr;
            logic signed [W+17:0] sum;
            assign role   = ROLE_IN[2*g +: 2];
            assign sel    = REFERENCE_SELECT_IN[2*g +: 2];
            assign active = PROX_IN[g] | TOUCH_IN[g];

            beta_iir #(.W(W)) u_long (
                .base_in   (long_q[g*W +: W]),
                .sample_in (COUNTS_IN[g*W +: W]),
                .beta_in   (LONG_BETA_IN),
                .next_out  (long_filt[g*W +: W])
            );
            // Filtered every sample, even in prox or touch
            beta_iir #(.W(W)) u_settle (
                .base_in   (settle_q[g*W +: W]),
                .sample_in (COUNTS_IN[g*W +: W]),
                .beta_in   (SETTLE_BETA_IN),
                .next_out  (settle_filt[g*W +: W])
            );

            release_detect #(.W(W), .CW(CW)) u_rel (
                .clk_in         (CLK_IN),
                .ce_in          (CE_IN),
                .rst_n_in       (RESETN_IN),
                .step_in        (state_q == baseline_track_pkg::ST_COMMIT),
                .enable_in      (RELEASE_ENABLE_IN),
                .active_in      (active),
                .counts_in      (COUNTS_IN[g*W +: W]),
                .settle_base_in (settle_q[g*W +: W]),
                .long_base_in   (long_q[g*W +: W]),
                .settle_thr_in  (SETTLE_THRESHOLD_IN),
                .delay_in       (SNAPSHOT_DELAY_IN),
                .pct_in         (RELEASE_PERCENT_IN),
                .snapshot_out   (snap_w[g*W +: W]),
                .release_out    (release_w[g])
            );

            // Mask only counts in reference role; own bits ignored if wrong
            assign inhibit_w[g] = (role == `ROLE_REFERENCE)
                                  && |(EVENT_MASK_IN[8*g +: 8] & status_hi[7:0]);

            // Drift of the selected reference, weighted as 12-bit fraction
            always_comb begin
                drift = $signed({1'b0, long_q[sel*W +: W]})
                        - $signed({1'b0, long_prev_q[sel*W +: W]});
                prod  = drift * $signed({1'b0, WEIGHT_IN[16*g +: 16]});
                corr  = prod >>> `WEIGHT_FRAC_BITS;
                sum   = $signed({18'h0, long_q[g*W +: W]}) - corr;
                if (active) begin
                    // Frozen while active; follower still gets drift correction
                    if (role == `ROLE_FOLLOWER) begin
                        long_d[g*W +: W] = sum[W+17] ? '0 : W'(sum);
                    end else begin
                        long_d[g*W +: W] = long_q[g*W +: W];
                    end
                end else begin
                    long_d[g*W +: W] = long_filt[g*W +: W];
                end
            end

            // Baselines commit once per sample; reseed loads counts
            always_ff @(posedge CLK_IN) begin
                if (!RESETN_IN) begin
                    long_q[g*W +: W]      <= '0;
                    long_prev_q[g*W +: W] <= '0;
                    settle_q[g*W +: W]    <= '0;
                end else if (CE_IN && state_q == baseline_track_pkg::ST_COMMIT) begin
                    long_prev_q[g*W +: W] <= long_q[g*W +: W];
                    settle_q[g*W +: W]    <= settle_filt[g*W +: W];
                    if (release_w[g]) begin
                        long_q[g*W +: W] <= COUNTS_IN[g*W +: W];
                    end else begin
                        long_q[g*W +: W] <= long_d[g*W +: W];
                    end
                end
            end
        end
    endgenerate

    // Registered outputs; reseed is a one-cycle pulse per sample
    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            LONG_TERM_BASELINE_OUT       <= '0;
            SETTLE_TRACKING_BASELINE_OUT <= '0;
            DELTA_SNAPSHOT_OUT           <= '0;
            AUTO_TUNING_INHIBIT_OUT      <= '0;
            RESEED_OUT                   <= '0;
            DONE_OUT                     <= 1'b0;
        end else if (CE_IN) begin
            LONG_TERM_BASELINE_OUT       <= long_q;
            SETTLE_TRACKING_BASELINE_OUT <= settle_q;
            DELTA_SNAPSHOT_OUT           <= snap_w;
            AUTO_TUNING_INHIBIT_OUT      <= inhibit_w;
            RESEED_OUT <= (state_q == baseline_track_pkg::ST_COMMIT) ? release_w : '0;
            DONE_OUT   <= (state_q == baseline_track_pkg::ST_COMMIT);
        end
    end
endmodule
`default_nettype wire

// ===== hw/baseline_track_defs.svh
// Behaviour
// - Follower baseline minus reference baseline drift
// - Correction only while follower in prox/touch
// - One reference may feed many followers
// - Role per channel: independent, reference, follower
// - Reference select picks reference for follower
// - Masked prox/touch flags inhibit reference auto-tuning
// - Event mask used only in reference role
// - Mask bits 0/1 map channel 0 prox/touch
// - Correction scaled by weight over 4096
// - Settle tracking baseline filtered every sample
// - Long-term baseline frozen during prox/touch, except follower drift correction and reseed
// - Count settled samples, arm past delay
// - Snapshot abs(baseline minus counts) when settled
// - Release level is snapshot times percent/128
// - Counts minus settle baseline over level reseeds
// - Settle tracking baseline readable per channel
// - Release detection only when feature enabled
`ifndef BASELINE_TRACK_DEFS_SVH
`define BASELINE_TRACK_DEFS_SVH
`define WEIGHT_FRAC_BITS   12
`define WEIGHT_UNITY       16'h1000
`define RELEASE_PCT_SHIFT  7
`define ROLE_INDEPENDENT   2'h0
`define ROLE_REFERENCE     2'h1
`define ROLE_FOLLOWER      2'h2
`define STATUS_PROX_BIT    0
`define STATUS_TOUCH_BIT   1
`endif

// ===== hw/baseline_track_pkg.sv
package baseline_track_pkg;
    typedef enum logic [1:0] {
        ROLE_INDEP    = 2'h0,
        ROLE_REF      = 2'h1,
        ROLE_FOLLOWER = 2'h2
    } role_t;
    typedef enum logic [2:0] {
        ST_IDLE    = 3'h1,
        ST_COMPUTE = 3'h2,
        ST_COMMIT  = 3'h4
    } seq_t;
endpackage

// ===== hw/beta_iir.sv
`timescale 1ns/100ps
`default_nettype none
// One IIR beta step: y += (x - y) >> beta
module beta_iir #(
    parameter int W = 16
) (
    input  wire logic [W-1:0] base_in,
    input  wire logic [W-1:0] sample_in,
    input  wire logic [3:0]   beta_in,
    output logic      [W-1:0] next_out
);
    logic signed [W:0] diff;
    logic signed [W:0] step;
    // Arithmetic shift keeps sign so the filter tracks both ways
    always_comb begin
        diff     = $signed({1'b0, sample_in}) - $signed({1'b0, base_in});
        step     = diff >>> beta_in;
        next_out = W'($signed({1'b0, base_in}) + step);
    end
endmodule
`default_nettype wire

// ===== hw/release_detect.sv
`timescale 1ns/100ps
`default_nettype none
`include "baseline_track_defs.svh"
// Per-channel settle counting, snapshot and release compare
module release_detect #(
    parameter int W  = 16,
    parameter int CW = 8
) (
    input  wire logic          clk_in,
    input  wire logic          ce_in,
    input  wire logic          rst_n_in,
    input  wire logic          step_in,
    input  wire logic          enable_in,
    input  wire logic          active_in,
    input  wire logic [W-1:0]  counts_in,
    input  wire logic [W-1:0]  settle_base_in,
    input  wire logic [W-1:0]  long_base_in,
    input  wire logic [W-1:0]  settle_thr_in,
    input  wire logic [CW-1:0] delay_in,
    input  wire logic [7:0]    pct_in,
    output logic      [W-1:0]  snapshot_out,
    output logic               release_out
);
    logic [CW-1:0]  settle_cnt_q;
    logic [W-1:0]   snap_q;
    logic signed [W:0] rise;
    logic [W-1:0]   abs_rise;
    logic [W-1:0]   abs_delta;
    logic [W+7:0]   scaled;
    logic [W+7:0]   level;
    // Signed rise of counts above the settle baseline
    always_comb begin
        rise      = $signed({1'b0, counts_in}) - $signed({1'b0, settle_base_in});
        abs_rise  = rise[W] ? W'(-rise) : rise[W-1:0];
        abs_delta = (long_base_in > counts_in) ? long_base_in - counts_in
                                               : counts_in - long_base_in;
        // Widen before the product so large snapshots do not wrap
        scaled    = (W+8)'(snap_q) * (W+8)'(pct_in);
        level     = scaled >> `RELEASE_PCT_SHIFT;
    end
    // Consecutive settled samples; saturates to avoid wrap re-arming
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !enable_in) begin
            settle_cnt_q <= '0;
        end else if (ce_in && step_in) begin
            if (abs_rise < settle_thr_in) begin
                if (settle_cnt_q != '1) settle_cnt_q <= settle_cnt_q + 1'b1;
            end else begin
                settle_cnt_q <= '0;
            end
        end
    end
    // Snapshot taken each sample once armed
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            snap_q <= '0;
        end else if (ce_in && step_in && enable_in && abs_rise < settle_thr_in
                     && settle_cnt_q > delay_in) begin
            snap_q <= abs_delta;
        end
    end
    // Release compare, only in an active state with feature on
    always_comb begin
        snapshot_out = snap_q;
        release_out  = enable_in && active_in && !rise[W]
                       && ((W+8)'(rise[W-1:0]) > level);
    end
endmodule
`default_nettype wire

// ===== testbench/baseline_track_props.sv
`timescale 1ns/100ps
`default_nettype none
// Port-level checks of the baseline tracking block
module baseline_track_props #(
    parameter int NCH = 3,
    parameter int W   = 16,
    parameter int CW  = 8
) (
    input wire logic             CLK_IN,
    input wire logic             RESETN_IN,
    input wire logic             CE_IN,
    input wire logic             SAMPLE_STROBE_IN,
    input wire logic [NCH-1:0]   PROX_IN,
    input wire logic [NCH-1:0]   TOUCH_IN,
    input wire logic [NCH*2-1:0] ROLE_IN,
    input wire logic [NCH*8-1:0] EVENT_MASK_IN,
    input wire logic             RELEASE_ENABLE_IN,
    input wire logic [NCH*W-1:0] LONG_TERM_BASELINE_OUT,
    input wire logic [NCH*W-1:0] SETTLE_TRACKING_BASELINE_OUT,
    input wire logic [NCH*W-1:0] DELTA_SNAPSHOT_OUT,
    input wire logic [NCH-1:0]   AUTO_TUNING_INHIBIT_OUT,
    input wire logic [NCH-1:0]   RESEED_OUT,
    input wire logic             DONE_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESETN_IN);
    logic [7:0] flags;
    // Status upper byte: two flags per channel, four channels fit
    always_comb begin
        flags = 8'h00;
        for (int c = 0; c < NCH && c < 4; c++) begin
            flags[2*c] = PROX_IN[c];
            flags[2*c+1] = TOUCH_IN[c];
        end
    end
    done_latency_a: assert property (DONE_OUT |-> $past(SAMPLE_STROBE_IN, 3))
        else $error("done without strobe three cycles before");
    done_pulse_a: assert property ((DONE_OUT && CE_IN) |=> !DONE_OUT)
        else $error("done longer than one cycle");
    reseed_done_a: assert property ((|RESEED_OUT) |-> DONE_OUT)
        else $error("reseed outside pass end");
    reseed_enable_a: assert property ((|RESEED_OUT) |-> RELEASE_ENABLE_IN)
        else $error("reseed while release disabled");
    reset_clear_a: assert property ((RESETN_IN && !$past(RESETN_IN)) |->
        (DONE_OUT == 1'b0 && RESEED_OUT == '0 && LONG_TERM_BASELINE_OUT == '0))
        else $error("outputs not clear after reset");
    out_hold_a: assert property ((!DONE_OUT && !$past(DONE_OUT)) |-> $stable(
        {LONG_TERM_BASELINE_OUT, SETTLE_TRACKING_BASELINE_OUT, DELTA_SNAPSHOT_OUT}))
        else $error("baselines moved between passes");
    // Per-channel relations
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        inhibit_map_a: assert property (($past(RESETN_IN) && $past(CE_IN)) |->
            AUTO_TUNING_INHIBIT_OUT[c] == $past(ROLE_IN[2*c+:2] == baseline_track_pkg::ROLE_REF
            && |(EVENT_MASK_IN[8*c+:8] & flags)))
            else $error("inhibit does not follow masked flags");
        reseed_active_a: assert property (RESEED_OUT[c] |-> (PROX_IN[c] || TOUCH_IN[c]))
            else $error("reseed on idle channel");
    end
endmodule
bind baseline_track baseline_track_props #(.NCH(NCH), .W(W), .CW(CW)) props_i (
    .CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .CE_IN(CE_IN),
    .SAMPLE_STROBE_IN(SAMPLE_STROBE_IN),
    .PROX_IN(PROX_IN), .TOUCH_IN(TOUCH_IN), .ROLE_IN(ROLE_IN), .EVENT_MASK_IN(EVENT_MASK_IN),
    .RELEASE_ENABLE_IN(RELEASE_ENABLE_IN), .LONG_TERM_BASELINE_OUT(LONG_TERM_BASELINE_OUT),
    .SETTLE_TRACKING_BASELINE_OUT(SETTLE_TRACKING_BASELINE_OUT),
    .DELTA_SNAPSHOT_OUT(DELTA_SNAPSHOT_OUT), .AUTO_TUNING_INHIBIT_OUT(AUTO_TUNING_INHIBIT_OUT),
    .RESEED_OUT(RESEED_OUT), .DONE_OUT(DONE_OUT));
`default_nettype wire

// ===== testbench/baseline_track_tb.sv
`timescale 1ns/100ps
`default_nettype none
module baseline_track_tb;
    logic        clk;
    logic        resetn;
    logic        ce;
    logic        strobe;
    logic        rel_en;
    logic [15:0] cnt [3];
    logic [2:0]  prox;
    logic [2:0]  touch;
    logic [5:0]  role;
    logic [5:0]  rsel;
    logic [23:0] mask;
    logic [47:0] wgt;
    logic [3:0]  sbeta;
    logic [47:0] lt_o;
    logic [47:0] st_o;
    logic [47:0] sn_o;
    logic [2:0]  inh_o;
    logic [2:0]  rs_o;
    logic        done_o;
    logic [2:0]  rs_seen;
    logic [15:0] b0;
    logic [15:0] b2;
    int          fail_count;
    int          n_tests;
    always #20 clk = ~clk;
    // Long beta zero makes an unfrozen baseline jump to counts in one pass
    baseline_track #(.NCH(3), .W(16), .CW(8)) baseline_track_i (
        .CLK_IN(clk), .RESETN_IN(resetn), .CE_IN(ce), .SAMPLE_STROBE_IN(strobe),
        .COUNTS_IN({cnt[2], cnt[1], cnt[0]}), .PROX_IN(prox), .TOUCH_IN(touch),
        .ROLE_IN(role), .REFERENCE_SELECT_IN(rsel), .EVENT_MASK_IN(mask),
        .WEIGHT_IN(wgt), .LONG_BETA_IN(4'h0), .SETTLE_BETA_IN(sbeta),
        .RELEASE_ENABLE_IN(rel_en), .SETTLE_THRESHOLD_IN(16'h0030),
        .SNAPSHOT_DELAY_IN(8'h02), .RELEASE_PERCENT_IN(8'h80),
        .LONG_TERM_BASELINE_OUT(lt_o), .SETTLE_TRACKING_BASELINE_OUT(st_o),
        .DELTA_SNAPSHOT_OUT(sn_o), .AUTO_TUNING_INHIBIT_OUT(inh_o),
        .RESEED_OUT(rs_o), .DONE_OUT(done_o));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic summarize;
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // One pass; reseed caught with done, then one cycle for new baselines
    task automatic pass;
        int k;
        k = 0;
        @(negedge clk);
        strobe = 1'b1;
        @(negedge clk);
        strobe = 1'b0;
        while (done_o !== 1'b1 && k < 8) begin
            @(negedge clk);
            k++;
        end
        if (k == 8) begin
            fail_count++;
            summarize();
        end
        rs_seen = rs_o;
        @(negedge clk);
    endtask
    task automatic t_freeze;
        pass();
        for (int c = 0; c < 3; c++) begin
            chk("long", cnt[c], lt_o[16*c+:16]);
            chk("settle", cnt[c], st_o[16*c+:16]);
        end
        b0 = cnt[0];
        prox = 3'h1;
        cnt[0] = cnt[0] + 16'h0020;
        cnt[1] = cnt[1] + 16'h0020;
        pass();
        chk("frozen", b0, lt_o[15:0]);
        chk("other", cnt[1], lt_o[31:16]);
        chk("settle0", cnt[0], st_o[15:0]);
        prox = 3'h0;
        pass();
    endtask
    // Enable low: a strobe is ignored and nothing moves
    task automatic t_hold;
        logic seen;
        seen = 1'b0;
        b0 = lt_o[31:16];
        @(negedge clk);
        ce = 1'b0;
        strobe = 1'b1;
        cnt[1] = cnt[1] + 16'h0010;
        @(negedge clk);
        strobe = 1'b0;
        repeat (4) begin
            @(negedge clk);
            seen = seen | done_o;
        end
        ce = 1'b1;
        repeat (4) begin
            @(negedge clk);
            seen = seen | done_o;
        end
        chk("hold done", 16'h0000, {15'h0, seen});
        chk("hold base", b0, lt_o[31:16]);
        cnt[1] = cnt[1] - 16'h0010;
    endtask
    // Ch1 reference for followers ch0 and ch2
    task automatic t_follow;
        role = 6'h26;
        rsel = 6'h11;
        mask = 24'h003303;
        pass();
        prox = 3'h1;
        touch = 3'h4;
        b0 = lt_o[15:0];
        b2 = lt_o[47:32];
        pass();
        chk("inhibit", 16'h0002, {13'h0, inh_o});
        cnt[1] = cnt[1] + 16'h0100;
        pass();
        pass();
        chk("follow", b0 - 16'h0100, lt_o[15:0]);
        wgt[15:0] = 16'h0800;
        cnt[1] = cnt[1] + 16'h0101;
        pass();
        pass();
        chk("weight", b0 - 16'h0180, lt_o[15:0]);
        chk("second", b2 - 16'h0201, lt_o[47:32]);
        role = 6'h00;
        prox = 3'h0;
        touch = 3'h0;
        pass();
        chk("inhibit", 16'h0000, {13'h0, inh_o});
    endtask
    // Counts drop, settle follows, snapshot taken, then a rise releases
    task automatic t_release;
        rel_en = 1'b1;
        touch = 3'h1;
        b0 = cnt[0];
        cnt[0] = cnt[0] - 16'h0040;
        pass();
        pass();
        chk("early snap", 16'h0000, sn_o[15:0]);
        repeat (3) pass();
        chk("snapshot", 16'h0040, sn_o[15:0]);
        sbeta = 4'hf;
        cnt[0] = b0;
        pass();
        chk("at level", 16'h0000, {13'h0, rs_seen});
        rel_en = 1'b0;
        cnt[0] = b0 + 16'h0001;
        pass();
        chk("disabled", 16'h0000, {13'h0, rs_seen});
        rel_en = 1'b1;
        pass();
        chk("reseed", 16'h0001, {13'h0, rs_seen});
        chk("reseed base", cnt[0], lt_o[15:0]);
        touch = 3'h0;
    endtask
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        ce = 1'b1;
        touch = 3'h0;
        strobe = 1'b0;
        rel_en = 1'b0;
        prox = 3'h0;
        role = 6'h00;
        rsel = 6'h00;
        mask = 24'h000000;
        wgt = {3{16'h1000}};
        sbeta = 4'h0;
        cnt[0] = 16'h1230;
        cnt[1] = 16'h2340;
        cnt[2] = 16'h3450;
        fail_count = 0;
        n_tests = 0;
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        chk("reset base", 16'h0000, lt_o[15:0]);
        t_freeze();
        t_hold();
        t_follow();
        t_release();
        summarize();
    end
endmodule
`default_nettype wire
